// ### pkg/mie_pkg.sv
package mie_pkg;

  // Register map, byte addresses on the Avalon-MM slave
  localparam logic [15:0] REG_CMD    = 16'h0000;
  localparam logic [15:0] REG_ACC    = 16'h0004;
  localparam logic [15:0] REG_STATUS = 16'h0008;
  localparam logic [15:0] REG_CTRL   = 16'h000c;
  localparam logic [15:0] REG_PC     = 16'h0010;
  localparam logic [15:0] REG_TBLP   = 16'h0014;
  localparam logic [15:0] REG_TABLE_HIGH_LATCH   = 16'h0018;
  // Data memory window: one byte per word, 256 bytes
  localparam logic [5:0]  DM_WIN_TAG = 6'h01;
  // Program memory window: one 16-bit word per bus word, address bit 15 set
  localparam int unsigned PM_WIN_BIT = 15;

  // Command word fields
  localparam int unsigned CMD_IMM_LSB  = 0;
  localparam int unsigned CMD_ADDR_LSB = 8;
  localparam int unsigned CMD_BIT_LSB  = 16;
  localparam int unsigned CMD_OP_LSB   = 24;

  // Status bits
  localparam int unsigned ST_CARRY_BIT   = 0;
  localparam int unsigned ST_TIMEOUT_BIT = 1;
  localparam int unsigned ST_PDOWN_BIT   = 2;
  localparam int unsigned ST_HALT_BIT    = 3;
  localparam int unsigned ST_INTEN_BIT   = 4;
  // Control bits
  localparam int unsigned CTRL_WDT_EN_BIT = 0;
  localparam int unsigned CTRL_WAKE_BIT   = 1;

  // Data memory address that aliases the low program counter byte
  localparam logic [7:0] PCL_ADDR = 8'h02;

  // Reset values
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic [7:0] TBLP_RST   = 8'h00;
  localparam logic       WDT_EN_RST = 1'b0;

  // Watchdog timing defaults: prescale in clock cycles, ticks in prescaler periods
  localparam int unsigned WDT_PRESCALE_DEF = 256;
  localparam int unsigned WDT_TICKS_DEF    = 256;

  typedef enum logic [5:0] {
    OP_NOP                  = 6'h00,
    OP_ROT_R_IN_PLACE       = 6'h01,
    OP_ROT_R_TO_WORKING     = 6'h02,
    OP_ROT_R_VIA_CARRY      = 6'h03,
    OP_ROT_R_VIA_CARRY_WK   = 6'h04,
    OP_ROT_L_IN_PLACE       = 6'h05,
    OP_ROT_L_TO_WORKING     = 6'h06,
    OP_ROT_L_VIA_CARRY      = 6'h07,
    OP_ROT_L_VIA_CARRY_WK   = 6'h08,
    OP_MOVE_MEM_TO_WK       = 6'h09,
    OP_MOVE_WK_TO_MEM       = 6'h0a,
    OP_MOVE_IMM_TO_WK       = 6'h0b,
    OP_BIT_CLEAR            = 6'h0c,
    OP_BIT_SET              = 6'h0d,
    OP_JUMP_ABSOLUTE        = 6'h0e,
    OP_SKIP_IF_ZERO         = 6'h0f,
    OP_SKIP_IF_ZERO_COPY_WK = 6'h10,
    OP_SKIP_IF_BIT_CLEAR    = 6'h11,
    OP_SKIP_IF_BIT_SET      = 6'h12,
    OP_INC_SKIP_ON_ZERO     = 6'h13,
    OP_DEC_SKIP_ON_ZERO     = 6'h14,
    OP_INC_SKIP_ZERO_WK     = 6'h15,
    OP_DEC_SKIP_ZERO_WK     = 6'h16,
    OP_CALL                 = 6'h17,
    OP_RETURN               = 6'h18,
    OP_RETURN_IMM           = 6'h19,
    OP_INTERRUPT_RETURN     = 6'h1a,
    OP_TABLE_READ_CURRENT   = 6'h1b,
    OP_TABLE_READ_LAST      = 6'h1c,
    OP_MEM_CLEAR            = 6'h1d,
    OP_MEM_SET              = 6'h1e,
    OP_WATCHDOG_CLEAR       = 6'h1f,
    OP_WATCHDOG_PRE_FIRST   = 6'h20,
    OP_WATCHDOG_PRE_SECOND  = 6'h21,
    OP_NIBBLE_SWAP          = 6'h22,
    OP_NIBBLE_SWAP_WK       = 6'h23,
    OP_HALT                 = 6'h24
  } mie_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_EXTRA = 3'b100
  } mie_state_t;

  typedef enum logic [1:0] {
    PRE_NONE   = 2'b00,
    PRE_FIRST  = 2'b01,
    PRE_SECOND = 2'b10
  } mie_pre_t;

  typedef struct packed {
    logic [5:0] op;
    logic [2:0] bit_sel;
    logic [7:0] addr;
    logic [7:0] imm;
  } mie_instr_t;

  typedef struct packed {
    logic       acc_we;
    logic [7:0] acc_val;
    logic       mem_we;
    logic [7:0] mem_val;
    logic       carry_we;
    logic       carry_val;
    logic       skip;
  } mie_result_t;

endpackage

// ### hdl/mie_exec_core.sv
// Function
// - Rotate memory byte right one bit to working or memory, one cycle, no flags.
// - Rotate right through carry to working or memory, only carry changes.
// - Rotate memory byte left one bit to working or memory, no flags.
// - Rotate left through carry to working or memory, only carry changes.
// - Move memory to working, working to memory, immediate to working; one cycle.
// - Clear or set one chosen memory bit in one cycle, no flags.
// - Skip next instruction when memory byte is zero; variant copies it, no flags.
// - Zero test copy variant loads tested byte into working and still skips.
// - Skip next instruction when the chosen memory bit is zero.
// - Skip next instruction when the chosen memory bit is one.
// - Increment byte to memory or working only; skip when result is zero.
// - Decrement byte to memory or working only; skip on zero, no flags.
// - Skip instructions take two cycles when skipping, otherwise one.
// - Writing the low program counter byte takes two cycles; jump takes two.
// - Return, return with immediate, interrupt return: two cycles, no flags; interrupt return sets interrupt enable.
// - Current page table read: high part to latch, low byte to memory, two cycles.
// - Last page table read: latch and memory byte loaded in two cycles.
// - Clear a memory byte to zeros or set it to ones, one cycle.
// - Watchdog clear runs in one cycle, clears timeout and power down flags.
// - Two pre-clears clear the flags only when issued consecutively as a pair.
// - Swap nibbles of a byte to memory or working only, no flags.
// - Halt stops execution, keeps state, clears watchdog, sets power down flag.
// - Repeating one pre-clear without the other has no effect.
`timescale 1ns/1ps
module mie_exec_core #(
  parameter int unsigned PC_W         = 10,
  parameter int unsigned STACK_DEPTH  = 16,
  parameter int unsigned WDT_PRESCALE = mie_pkg::WDT_PRESCALE_DEF,
  parameter int unsigned WDT_TICKS    = mie_pkg::WDT_TICKS_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             halted_o
);

  if (PC_W < 9 || PC_W > 13) begin : g_pc_w_check
    $error("PC_W must lie between 9 and 13");
  end
  if (STACK_DEPTH < 2 || WDT_PRESCALE < 2 || WDT_TICKS < 2) begin : g_depth_check
    $error("STACK_DEPTH, WDT_PRESCALE and WDT_TICKS must be at least 2");
  end

  localparam int unsigned SP_W  = $clog2(STACK_DEPTH);
  localparam int unsigned PRE_W = $clog2(WDT_PRESCALE);
  localparam int unsigned TCK_W = $clog2(WDT_TICKS);
  localparam int unsigned PM_N  = 2 ** PC_W;

  logic [7:0]      dm    [256];
  logic [15:0]     pm    [PM_N];
  logic [PC_W-1:0] stack [STACK_DEPTH];

  mie_pkg::mie_state_t  state_r;
  mie_pkg::mie_instr_t  ir_r;
  mie_pkg::mie_pre_t    pre_last_r;
  mie_pkg::mie_result_t res;
  logic [7:0]      acc_r;
  logic            carry_r;
  logic            wdt_timeout_r;
  logic            pdown_r;
  logic            halted_r;
  logic            inten_r;
  logic            wdt_en_r;
  logic [PC_W-1:0] pc_r;
  logic [7:0]      tblp_r;
  logic [7:0]      table_high_latch_r;
  logic [SP_W-1:0] sp_r;
  logic [PRE_W-1:0] wdt_pre_r;
  logic [TCK_W-1:0] wdt_cnt_r;
  logic            rd_done_r;
  logic [31:0]     rdata_r;

  function automatic logic [7:0] mem_rd(input logic [7:0] a);
    return (a == mie_pkg::PCL_ADDR) ? pc_r[7:0] : dm[a];
  endfunction

  // Bus decode
  wire        sel_cmd    = avs_address_i == mie_pkg::REG_CMD;
  wire        sel_acc    = avs_address_i == mie_pkg::REG_ACC;
  wire        sel_status = avs_address_i == mie_pkg::REG_STATUS;
  wire        sel_ctrl   = avs_address_i == mie_pkg::REG_CTRL;
  wire        sel_pc     = avs_address_i == mie_pkg::REG_PC;
  wire        sel_tblp   = avs_address_i == mie_pkg::REG_TBLP;
  wire        sel_table_high_latch   = avs_address_i == mie_pkg::REG_TABLE_HIGH_LATCH;
  wire        sel_dm     = avs_address_i[15:10] == mie_pkg::DM_WIN_TAG;
  wire [7:0]  dm_idx     = avs_address_i[9:2];
  wire [12:0] pm_word    = avs_address_i[14:2];
  wire        sel_pm     = avs_address_i[mie_pkg::PM_WIN_BIT] && (14'(pm_word) < 14'(PM_N));
  wire [PC_W-1:0] pm_idx = pm_word[PC_W-1:0];

  wire cmd_full  = avs_byteenable_i == 4'hf;
  wire cmd_start = (state_r == mie_pkg::ST_IDLE) && avs_write_i && sel_cmd && cmd_full
                   && !halted_r;
  wire in_exec   = state_r == mie_pkg::ST_EXEC;

  // Execute stage decode
  mie_pkg::mie_op_t op;
  assign op = mie_pkg::mie_op_t'(ir_r.op);
  wire [7:0] m_val   = mem_rd(ir_r.addr);
  wire [7:0] m_inc   = m_val + 8'h01;
  wire [7:0] m_dec   = m_val - 8'h01;
  wire [7:0] bmask   = 8'h01 << ir_r.bit_sel;
  wire       bit_hit = (m_val & bmask) != 8'h00;

  wire op_jump  = op == mie_pkg::OP_JUMP_ABSOLUTE;
  wire op_call  = op == mie_pkg::OP_CALL;
  wire op_interrupt_return  = op == mie_pkg::OP_INTERRUPT_RETURN;
  wire op_ret   = (op == mie_pkg::OP_RETURN) || (op == mie_pkg::OP_RETURN_IMM) || op_interrupt_return;
  wire op_tcur  = op == mie_pkg::OP_TABLE_READ_CURRENT;
  wire op_tlast = op == mie_pkg::OP_TABLE_READ_LAST;
  wire op_tab   = op_tcur || op_tlast;
  wire op_halt  = op == mie_pkg::OP_HALT;
  wire op_pre1  = op == mie_pkg::OP_WATCHDOG_PRE_FIRST;
  wire op_pre2  = op == mie_pkg::OP_WATCHDOG_PRE_SECOND;

  // Table address: page from the program counter or the last page
  wire [PC_W-9:0] tab_page = op_tlast ? '1 : pc_r[PC_W-1:8];
  wire [15:0]     tab_word = pm[{tab_page, tblp_r}];

  always_comb begin
    res = '0;
    unique case (op)
      mie_pkg::OP_ROT_R_IN_PLACE: begin
        res.mem_we  = 1'b1;
        res.mem_val = {m_val[0], m_val[7:1]};
      end
      mie_pkg::OP_ROT_R_TO_WORKING: begin
        res.acc_we  = 1'b1;
        res.acc_val = {m_val[0], m_val[7:1]};
      end
      mie_pkg::OP_ROT_R_VIA_CARRY: begin
        res.mem_we    = 1'b1;
        res.mem_val   = {carry_r, m_val[7:1]};
        res.carry_we  = 1'b1;
        res.carry_val = m_val[0];
      end
      mie_pkg::OP_ROT_R_VIA_CARRY_WK: begin
        res.acc_we    = 1'b1;
        res.acc_val   = {carry_r, m_val[7:1]};
        res.carry_we  = 1'b1;
        res.carry_val = m_val[0];
      end
      mie_pkg::OP_ROT_L_IN_PLACE: begin
        res.mem_we  = 1'b1;
        res.mem_val = {m_val[6:0], m_val[7]};
      end
      mie_pkg::OP_ROT_L_TO_WORKING: begin
        res.acc_we  = 1'b1;
        res.acc_val = {m_val[6:0], m_val[7]};
      end
      mie_pkg::OP_ROT_L_VIA_CARRY: begin
        res.mem_we    = 1'b1;
        res.mem_val   = {m_val[6:0], carry_r};
        res.carry_we  = 1'b1;
        res.carry_val = m_val[7];
      end
      mie_pkg::OP_ROT_L_VIA_CARRY_WK: begin
        res.acc_we    = 1'b1;
        res.acc_val   = {m_val[6:0], carry_r};
        res.carry_we  = 1'b1;
        res.carry_val = m_val[7];
      end
      mie_pkg::OP_MOVE_MEM_TO_WK: begin
        res.acc_we  = 1'b1;
        res.acc_val = m_val;
      end
      mie_pkg::OP_MOVE_WK_TO_MEM: begin
        res.mem_we  = 1'b1;
        res.mem_val = acc_r;
      end
      mie_pkg::OP_MOVE_IMM_TO_WK: begin
        res.acc_we  = 1'b1;
        res.acc_val = ir_r.imm;
      end
      mie_pkg::OP_BIT_CLEAR: begin
        res.mem_we  = 1'b1;
        res.mem_val = m_val & ~bmask;
      end
      mie_pkg::OP_BIT_SET: begin
        res.mem_we  = 1'b1;
        res.mem_val = m_val | bmask;
      end
      mie_pkg::OP_SKIP_IF_ZERO: begin
        res.skip = m_val == 8'h00;
      end
      mie_pkg::OP_SKIP_IF_ZERO_COPY_WK: begin
        res.skip    = m_val == 8'h00;
        res.acc_we  = 1'b1;
        res.acc_val = m_val;
      end
      mie_pkg::OP_SKIP_IF_BIT_CLEAR: begin
        res.skip = !bit_hit;
      end
      mie_pkg::OP_SKIP_IF_BIT_SET: begin
        res.skip = bit_hit;
      end
      mie_pkg::OP_INC_SKIP_ON_ZERO: begin
        res.mem_we  = 1'b1;
        res.mem_val = m_inc;
        res.skip    = m_inc == 8'h00;
      end
      mie_pkg::OP_INC_SKIP_ZERO_WK: begin
        res.acc_we  = 1'b1;
        res.acc_val = m_inc;
        res.skip    = m_inc == 8'h00;
      end
      mie_pkg::OP_DEC_SKIP_ON_ZERO: begin
        res.mem_we  = 1'b1;
        res.mem_val = m_dec;
        res.skip    = m_dec == 8'h00;
      end
      mie_pkg::OP_DEC_SKIP_ZERO_WK: begin
        res.acc_we  = 1'b1;
        res.acc_val = m_dec;
        res.skip    = m_dec == 8'h00;
      end
      mie_pkg::OP_RETURN_IMM: begin
        res.acc_we  = 1'b1;
        res.acc_val = ir_r.imm;
      end
      mie_pkg::OP_TABLE_READ_CURRENT, mie_pkg::OP_TABLE_READ_LAST: begin
        res.mem_we  = 1'b1;
        res.mem_val = tab_word[7:0];
      end
      mie_pkg::OP_MEM_CLEAR: begin
        res.mem_we  = 1'b1;
        res.mem_val = 8'h00;
      end
      mie_pkg::OP_MEM_SET: begin
        res.mem_we  = 1'b1;
        res.mem_val = 8'hff;
      end
      mie_pkg::OP_NIBBLE_SWAP: begin
        res.mem_we  = 1'b1;
        res.mem_val = {m_val[3:0], m_val[7:4]};
      end
      mie_pkg::OP_NIBBLE_SWAP_WK: begin
        res.acc_we  = 1'b1;
        res.acc_val = {m_val[3:0], m_val[7:4]};
      end
      default: begin
        res = '0;
      end
    endcase
  end

  // Writes landing on the low program counter byte redirect flow
  wire pcl_wr   = res.mem_we && (ir_r.addr == mie_pkg::PCL_ADDR);
  wire two_cyc  = res.skip || pcl_wr || op_jump || op_call || op_ret || op_tab;
  wire [PC_W-1:0] target   = PC_W'({ir_r.addr, ir_r.imm});
  wire [PC_W-1:0] pc_inc   = pc_r + PC_W'(1);
  wire [PC_W-1:0] stack_tp = stack[sp_r - SP_W'(1)];
  wire [PC_W-1:0] pc_seq   = res.skip ? pc_r + PC_W'(2) : pc_inc;

  logic [PC_W-1:0] pc_nxt;
  always_comb begin
    if (op_jump || op_call) begin
      pc_nxt = target;
    end else if (op_ret) begin
      pc_nxt = stack_tp;
    end else if (pcl_wr) begin
      pc_nxt = {pc_r[PC_W-1:8], res.mem_val};
    end else begin
      pc_nxt = pc_seq;
    end
  end

  // Watchdog pair detection and clear sources
  wire pair_done  = in_exec && ((op_pre1 && pre_last_r == mie_pkg::PRE_SECOND) ||
                                (op_pre2 && pre_last_r == mie_pkg::PRE_FIRST));
  wire wdt_single = in_exec && (op == mie_pkg::OP_WATCHDOG_CLEAR);
  wire flag_clear = wdt_single || pair_done;
  wire halt_exec  = in_exec && op_halt;
  wire wdt_restart = flag_clear || halt_exec;
  wire pre_wrap   = wdt_pre_r == PRE_W'(WDT_PRESCALE - 1);
  wire tick_wrap  = wdt_cnt_r == TCK_W'(WDT_TICKS - 1);
  wire wdt_expire = wdt_en_r && pre_wrap && tick_wrap;

  // Bus slave handshake
  wire bus_rd_wait = avs_read_i && !rd_done_r;
  assign avs_waitrequest_o = bus_rd_wait || cmd_start || (in_exec && two_cyc);
  wire bus_wr  = avs_write_i && !avs_waitrequest_o && !sel_cmd;
  wire wr_lo   = bus_wr && avs_byteenable_i[0];
  wire wake_wr = wr_lo && sel_ctrl && avs_writedata_i[mie_pkg::CTRL_WAKE_BIT];

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_cmd) begin
      rd_mux = 32'(ir_r) << mie_pkg::CMD_IMM_LSB;
    end else if (sel_acc) begin
      rd_mux[7:0] = acc_r;
    end else if (sel_status) begin
      rd_mux[mie_pkg::ST_CARRY_BIT]   = carry_r;
      rd_mux[mie_pkg::ST_TIMEOUT_BIT] = wdt_timeout_r;
      rd_mux[mie_pkg::ST_PDOWN_BIT]   = pdown_r;
      rd_mux[mie_pkg::ST_HALT_BIT]    = halted_r;
      rd_mux[mie_pkg::ST_INTEN_BIT]   = inten_r;
    end else if (sel_ctrl) begin
      rd_mux[mie_pkg::CTRL_WDT_EN_BIT] = wdt_en_r;
    end else if (sel_pc) begin
      rd_mux[PC_W-1:0] = pc_r;
    end else if (sel_tblp) begin
      rd_mux[7:0] = tblp_r;
    end else if (sel_table_high_latch) begin
      rd_mux[7:0] = table_high_latch_r;
    end else if (sel_dm) begin
      rd_mux[7:0] = mem_rd(dm_idx);
    end else if (sel_pm) begin
      rd_mux[15:0] = pm[pm_idx];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_done_r <= 1'b0;
      rdata_r   <= 32'h0000_0000;
    end else begin
      rd_done_r <= bus_rd_wait;
      if (bus_rd_wait) begin
        rdata_r <= rd_mux;
      end
    end
  end
  assign avs_readdata_o = rdata_r;

  // Sequencer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= mie_pkg::ST_IDLE;
      ir_r    <= '0;
    end else begin
      unique case (state_r)
        mie_pkg::ST_IDLE: begin
          if (cmd_start) begin
            state_r <= mie_pkg::ST_EXEC;
            ir_r    <= {avs_writedata_i[mie_pkg::CMD_OP_LSB +: 6],
                        avs_writedata_i[mie_pkg::CMD_IMM_LSB +: 19]};
          end
        end
        mie_pkg::ST_EXEC: begin
          state_r <= two_cyc ? mie_pkg::ST_EXTRA : mie_pkg::ST_IDLE;
        end
        mie_pkg::ST_EXTRA: begin
          state_r <= mie_pkg::ST_IDLE;
        end
        default: begin
          state_r <= mie_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Core registers updated by execution or by the bus
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_r    <= mie_pkg::ACC_RST;
      carry_r  <= 1'b0;
      pc_r     <= '0;
      sp_r     <= '0;
      tblp_r   <= mie_pkg::TBLP_RST;
      table_high_latch_r   <= 8'h00;
      inten_r  <= 1'b0;
      wdt_en_r <= mie_pkg::WDT_EN_RST;
    end else if (in_exec) begin
      if (res.acc_we) begin
        acc_r <= res.acc_val;
      end
      if (res.carry_we) begin
        carry_r <= res.carry_val;
      end
      if (!op_halt) begin
        pc_r <= pc_nxt;
      end
      if (op_call) begin
        sp_r <= sp_r + SP_W'(1);
      end else if (op_ret) begin
        sp_r <= sp_r - SP_W'(1);
      end
      if (op_tab) begin
        table_high_latch_r <= tab_word[15:8];
      end
      if (op_interrupt_return) begin
        inten_r <= 1'b1;
      end
    end else if (bus_wr) begin
      if (wr_lo && sel_acc) begin
        acc_r <= avs_writedata_i[7:0];
      end
      if (wr_lo && sel_status) begin
        carry_r <= avs_writedata_i[mie_pkg::ST_CARRY_BIT];
        inten_r <= avs_writedata_i[mie_pkg::ST_INTEN_BIT];
      end
      if (wr_lo && sel_ctrl) begin
        wdt_en_r <= avs_writedata_i[mie_pkg::CTRL_WDT_EN_BIT];
      end
      if (sel_pc && avs_byteenable_i[1:0] == 2'b11) begin
        pc_r <= avs_writedata_i[PC_W-1:0];
      end
      if (wr_lo && sel_tblp) begin
        tblp_r <= avs_writedata_i[7:0];
      end
    end
  end

  // Watchdog, power down and halt state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdt_pre_r     <= '0;
      wdt_cnt_r     <= '0;
      wdt_timeout_r <= 1'b0;
      pdown_r       <= 1'b0;
      halted_r      <= 1'b0;
      pre_last_r    <= mie_pkg::PRE_NONE;
    end else begin
      if (wdt_restart || !wdt_en_r) begin
        wdt_pre_r <= '0;
        wdt_cnt_r <= '0;
      end else begin
        wdt_pre_r <= pre_wrap ? '0 : wdt_pre_r + PRE_W'(1);
        if (pre_wrap) begin
          wdt_cnt_r <= tick_wrap ? '0 : wdt_cnt_r + TCK_W'(1);
        end
      end
      // A timeout in the same cycle as a clear still sets the flag
      if (wdt_expire) begin
        wdt_timeout_r <= 1'b1;
      end else if (flag_clear || halt_exec) begin
        wdt_timeout_r <= 1'b0;
      end
      if (halt_exec) begin
        pdown_r <= 1'b1;
      end else if (flag_clear) begin
        pdown_r <= 1'b0;
      end
      if (halt_exec) begin
        halted_r <= 1'b1;
      end else if (wdt_expire || wake_wr) begin
        halted_r <= 1'b0;
      end
      if (in_exec) begin
        if (pair_done) begin
          pre_last_r <= mie_pkg::PRE_NONE;
        end else if (op_pre1) begin
          pre_last_r <= mie_pkg::PRE_FIRST;
        end else if (op_pre2) begin
          pre_last_r <= mie_pkg::PRE_SECOND;
        end else begin
          pre_last_r <= mie_pkg::PRE_NONE;
        end
      end
    end
  end
  assign halted_o = halted_r;

  // Memories: data memory, program memory and return stack
  always_ff @(posedge clk_i) begin
    if (in_exec && res.mem_we && !pcl_wr) begin
      dm[ir_r.addr] <= res.mem_val;
    end else if (bus_wr && wr_lo && sel_dm && dm_idx != mie_pkg::PCL_ADDR) begin
      dm[dm_idx] <= avs_writedata_i[7:0];
    end
    if (bus_wr && sel_pm && avs_byteenable_i[1:0] == 2'b11) begin
      pm[pm_idx] <= avs_writedata_i[15:0];
    end
    if (in_exec && op_call) begin
      stack[sp_r] <= pc_inc;
    end
  end

endmodule // mie_exec_core

// ### verif/mie_exec_core_assertions.sv
`timescale 1ns/1ps
module mie_exec_core_checker (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [15:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        halted_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic            pend_r;
  wire logic [5:0] op  = avs_writedata_i[29:24];
  wire logic       npc = avs_writedata_i[15:8] != mie_pkg::PCL_ADDR;
  wire logic       cmd = avs_write_i && !pend_r && avs_address_i == mie_pkg::REG_CMD;
  wire logic       go  = cmd && avs_byteenable_i == 4'hf && !halted_o;
  // High once a request has waited, so only first cycles start a check
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pend_r <= 1'b0;
    else pend_r <= (avs_read_i || avs_write_i) && avs_waitrequest_o;
  end
  sequence one_cyc; avs_waitrequest_o ##1 !avs_waitrequest_o; endsequence
  sequence two_cyc; avs_waitrequest_o [*2] ##1 !avs_waitrequest_o; endsequence
  chk_rot_one_cyc: assert property (
    go && npc && op inside {[mie_pkg::OP_ROT_R_IN_PLACE:mie_pkg::OP_ROT_L_VIA_CARRY_WK]}
    |-> one_cyc) else $error("rotate length");
  chk_move_one_cyc: assert property (
    go && npc && op inside {[mie_pkg::OP_MOVE_MEM_TO_WK:mie_pkg::OP_BIT_SET]}
    |-> one_cyc) else $error("move or bit length");
  chk_misc_one_cyc: assert property (
    go && npc && op inside {[mie_pkg::OP_MEM_CLEAR:mie_pkg::OP_NIBBLE_SWAP_WK]}
    |-> one_cyc) else $error("misc length");
  chk_skip_len: assert property (
    go && npc && op inside {[mie_pkg::OP_SKIP_IF_ZERO:mie_pkg::OP_DEC_SKIP_ZERO_WK]}
    |-> one_cyc or two_cyc) else $error("skip length");
  chk_jump_two_cyc: assert property (
    go && (op == mie_pkg::OP_JUMP_ABSOLUTE || op == mie_pkg::OP_MOVE_WK_TO_MEM && !npc)
    |-> two_cyc) else $error("jump length");
  chk_ret_two_cyc: assert property (
    go && op inside {[mie_pkg::OP_RETURN:mie_pkg::OP_TABLE_READ_LAST]}
    |-> two_cyc) else $error("return or table length");
  chk_halt_entry: assert property (
    go && op == mie_pkg::OP_HALT |-> one_cyc ##1 halted_o) else $error("halt entry");
  chk_halt_refuse: assert property (
    cmd && halted_o |-> !avs_waitrequest_o) else $error("halted command ran");
endmodule // mie_exec_core_checker

bind mie_exec_core mie_exec_core_checker i_chk (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
  .halted_o);

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk_i            = 1'b0;
  logic        rst_n_i          = 1'b0;
  logic [15:0] avs_address_i    = 16'h0;
  logic        avs_read_i       = 1'b0;
  logic        avs_write_i      = 1'b0;
  logic [31:0] avs_writedata_i  = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        halted_o;
  logic [7:0]  ma = 8'h10;
  logic [31:0] d;
  int          n;
  int          ticks      = 0;
  int          fail_count = 0;
  int          num_checks = 0;
  mie_exec_core #(.WDT_PRESCALE(4), .WDT_TICKS(4)) i_dut (.clk_i, .rst_n_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .halted_o);
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic complete_run();
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (ticks == 4000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus transfer; n counts its cycles, d holds read data
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] v);
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= v;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(negedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0);
    @(posedge clk_i);
    d = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Presets byte, carry 1 and working 5a, runs op, checks length and results
  task automatic t(input mie_pkg::mie_op_t op, input logic [7:0] x, input logic [7:0] m0,
                   input logic [7:0] acc, input logic [7:0] mem, input logic c, input int cy);
    xfer(1'b1, {mie_pkg::DM_WIN_TAG, ma, 2'b00}, {24'h0, m0});
    xfer(1'b1, mie_pkg::REG_STATUS, 32'h1);
    xfer(1'b1, mie_pkg::REG_ACC, 32'h5a);
    xfer(1'b1, mie_pkg::REG_CMD, {2'b00, op, 5'h00, x[2:0], ma, x});
    chk("cycles", 32'(cy), 32'(n - 1));
    xfer(1'b0, mie_pkg::REG_ACC, 32'h0);
    chk("acc", {24'h0, acc}, d);
    xfer(1'b0, {mie_pkg::DM_WIN_TAG, ma, 2'b00}, 32'h0);
    chk("mem", {24'h0, mem}, d);
    xfer(1'b0, mie_pkg::REG_STATUS, 32'h0);
    chk("carry", {31'h0, c}, {31'h0, d[mie_pkg::ST_CARRY_BIT]});
  endtask
  task automatic ex(input mie_pkg::mie_op_t op, input int cy);
    t(op, 8'h00, 8'h00, 8'h5a, 8'h00, 1'b1, cy);
  endtask
  task automatic pd(input logic e);
    xfer(1'b0, mie_pkg::REG_STATUS, 32'h0);
    chk("power_down", {31'h0, e}, {31'h0, d[mie_pkg::ST_PDOWN_BIT]});
    chk("timeout", 32'h0, {31'h0, d[mie_pkg::ST_TIMEOUT_BIT]});
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    xfer(1'b1, mie_pkg::REG_TBLP, 32'h20);
    xfer(1'b1, 16'h8080, 32'hbea5);
    t(mie_pkg::OP_TABLE_READ_CURRENT, 8'h00, 8'h00, 8'h5a, 8'ha5, 1'b1, 2);
    xfer(1'b0, mie_pkg::REG_TABLE_HIGH_LATCH, 32'h0);
    chk("table_high", 32'hbe, d);
    t(mie_pkg::OP_ROT_R_VIA_CARRY, 8'h00, 8'h80, 8'h5a, 8'hc0, 1'b0, 1);
    t(mie_pkg::OP_ROT_L_VIA_CARRY_WK, 8'h00, 8'h40, 8'h81, 8'h40, 1'b0, 1);
    t(mie_pkg::OP_ROT_R_TO_WORKING, 8'h00, 8'h81, 8'hc0, 8'h81, 1'b1, 1);
    t(mie_pkg::OP_ROT_L_IN_PLACE, 8'h00, 8'h81, 8'h5a, 8'h03, 1'b1, 1);
    t(mie_pkg::OP_MOVE_IMM_TO_WK, 8'h3c, 8'h00, 8'h3c, 8'h00, 1'b1, 1);
    t(mie_pkg::OP_BIT_SET, 8'h07, 8'h00, 8'h5a, 8'h80, 1'b1, 1);
    t(mie_pkg::OP_SKIP_IF_ZERO_COPY_WK, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 2);
    t(mie_pkg::OP_SKIP_IF_BIT_CLEAR, 8'h03, 8'hf7, 8'h5a, 8'hf7, 1'b1, 2);
    t(mie_pkg::OP_SKIP_IF_BIT_SET, 8'h03, 8'hf7, 8'h5a, 8'hf7, 1'b1, 1);
    t(mie_pkg::OP_INC_SKIP_ON_ZERO, 8'h00, 8'hff, 8'h5a, 8'h00, 1'b1, 2);
    t(mie_pkg::OP_DEC_SKIP_ZERO_WK, 8'h00, 8'h01, 8'h00, 8'h01, 1'b1, 2);
    t(mie_pkg::OP_MEM_SET, 8'h00, 8'h00, 8'h5a, 8'hff, 1'b1, 1);
    t(mie_pkg::OP_NIBBLE_SWAP_WK, 8'h00, 8'h3c, 8'hc3, 8'h3c, 1'b1, 1);
    ex(mie_pkg::OP_JUMP_ABSOLUTE, 2);
    ma = 8'h02;
    t(mie_pkg::OP_MOVE_WK_TO_MEM, 8'h00, 8'h00, 8'h5a, 8'h5a, 1'b1, 2);
    ma = 8'h10;
    ex(mie_pkg::OP_HALT, 1);
    chk("halted", 32'h1, {31'h0, halted_o});
    pd(1'b1);
    ex(mie_pkg::OP_MOVE_IMM_TO_WK, 0);
    xfer(1'b1, mie_pkg::REG_CTRL, 32'h2);
    ex(mie_pkg::OP_WATCHDOG_PRE_FIRST, 1);
    ex(mie_pkg::OP_WATCHDOG_PRE_FIRST, 1);
    pd(1'b1);
    ex(mie_pkg::OP_WATCHDOG_PRE_SECOND, 1);
    pd(1'b0);
    ex(mie_pkg::OP_HALT, 1);
    xfer(1'b1, mie_pkg::REG_CTRL, 32'h1);
    repeat (20) @(posedge clk_i);
    chk("halted", 32'h0, {31'h0, halted_o});
    xfer(1'b1, mie_pkg::REG_CTRL, 32'h0);
    xfer(1'b0, mie_pkg::REG_STATUS, 32'h0);
    chk("timeout", 32'h1, {31'h0, d[mie_pkg::ST_TIMEOUT_BIT]});
    ex(mie_pkg::OP_WATCHDOG_CLEAR, 1);
    pd(1'b0);
    xfer(1'b1, mie_pkg::REG_PC, 32'h123);
    ex(mie_pkg::OP_CALL, 2);
    t(mie_pkg::OP_RETURN_IMM, 8'h77, 8'h00, 8'h77, 8'h00, 1'b1, 2);
    xfer(1'b0, mie_pkg::REG_PC, 32'h0);
    chk("pc", 32'h124, d);
    xfer(1'b1, 16'h8c80, 32'h5ac3);
    t(mie_pkg::OP_TABLE_READ_LAST, 8'h00, 8'h00, 8'h5a, 8'hc3, 1'b1, 2);
    xfer(1'b0, mie_pkg::REG_TABLE_HIGH_LATCH, 32'h0);
    chk("table_high", 32'h5a, d);
    complete_run();
  end
endmodule // testbench
